// File: design/uep_ctrl.sv
// uep_ctrl: programmer for a 1024 x 8 uv-erasable prom, loop method
// assumes level shifters turn select_program_level_out into 12 V and
// prog_pulse_out into the 25 V pulse; data pins are shared with reads
//
// How it works
// (R1) erased cells read one; programming only clears bits to zero
// (R2) a zero stays zero until uv erasure; the image only describes zeros
// (R3) select/write-enable goes to program level before any pulse
// (R4) in program mode the controller drives all eight data_lines
// (R5) words are addressed exactly as for reads
// (R6) one program pulse per presented address after setup
// (R7) every pass visits all 1024 addresses; n passes in a row
// (R8) start refused unless loops times pulse_width reaches total time
// (R9) pulse_width must lie between 0.1 and 1.0 ms
// (R10) never two pulses in succession on the same address
// (R11) select falls before the first address change after the last pulse
// (R12) program pin is actively driven low between pulses
// (R13) don't-care words are pulsed too, carrying all ones
// (R14) earlier data is rewritten every pass from the full image
// (R15) select edges fall after pulse edges and before address changes; at start, select rises in the same cycle as the address is reset to 0
// (R16) address wraps 1023 to 0; loop counter stops after n passes
// (R17) address and data hold steady around every pulse
`timescale 1ns/1ps
`include "uep_map.svh"

module uep_ctrl #(
  parameter int unsigned ADDR_W     = `UEP_ADDR_W,
  parameter int unsigned DATA_W     = `UEP_DATA_W,
  parameter int unsigned FIFO_DEPTH = `UEP_FIFO_DEPTH,
  parameter int unsigned TICK_CYC   = `UEP_TICK_CYC,
  parameter int unsigned PW_MIN_US  = `UEP_PW_MIN_US,
  parameter int unsigned PW_MAX_US  = `UEP_PW_MAX_US,
  parameter int unsigned TOTAL_US   = `UEP_TOTAL_US
) (
  input  wire logic              ref_clk_in,
  input  wire logic              sys_rst_in,
  input  wire logic              wr_valid_in,
  input  wire logic [DATA_W-1:0] wr_data_in,
  output logic                   wr_ready_out,
  output logic                   loaded_out,
  input  wire logic              start_in,
  input  wire logic [9:0]        pulse_width_in,
  input  wire logic [9:0]        loop_count_in,
  input  wire logic              rd_req_in,
  input  wire logic [ADDR_W-1:0] rd_addr_in,
  output logic [DATA_W-1:0]      rd_data_out,
  output logic                   rd_valid_out,
  output logic                   busy_out,
  output logic                   done_out,
  output logic                   err_out,
  output logic [9:0]             loop_out,
  output logic [ADDR_W-1:0]      addr_out,
  output logic [DATA_W-1:0]      data_lines_out,
  output logic                   data_lines_oe_out,
  input  wire logic [DATA_W-1:0] data_lines_in,
  output logic                   select_program_level_out,
  output logic                   prog_pulse_out
);

  localparam int unsigned WORDS      = 1 << ADDR_W;
  localparam int unsigned PW_MIN_CYC = PW_MIN_US * TICK_CYC;
  localparam int unsigned PW_MAX_CYC = PW_MAX_US * TICK_CYC;
  // last word of the part; address and load pointer wrap after it
  localparam logic [`UEP_ADDR_W-1:0] LAST_ADDR = `UEP_ADDR_W'(WORDS - 1);

  if (ADDR_W < 2 || ADDR_W > `UEP_ADDR_W || DATA_W != `UEP_DATA_W) begin : g_chk_w
    $error("uep_ctrl: widths must fit the state record");
  end
  if (PW_MIN_US == 0 || PW_MIN_US > PW_MAX_US || PW_MAX_US > 1023) begin : g_chk_pw
    $error("uep_ctrl: pulse width limits out of range");
  end

  uep_pkg::uep_regs_t q;
  uep_pkg::uep_regs_t d;

  // full image of the part; don't-care words must be loaded as all ones
  logic [DATA_W-1:0] img [WORDS];
  logic [DATA_W-1:0] fifo_data;
  logic              fifo_valid;
  logic              fifo_take;
  logic              tick;
  logic              tick_clr;
  logic [`UEP_ADDR_W-1:0] nxt_addr;

  function automatic logic hit(input logic [`UEP_CNT_W-1:0] c,
                               input int unsigned lim);
    return {21'h0, c} == lim - 1;
  endfunction

  function automatic logic start_ok(input logic [9:0] pw,
                                    input logic [9:0] n);
    int unsigned prod;
    prod = {22'h0, pw} * {22'h0, n};
    return ({22'h0, pw} >= PW_MIN_US) && ({22'h0, pw} <= PW_MAX_US) // R9
        && (n != 10'h000) && (prod >= TOTAL_US); // R8
  endfunction

  function automatic logic [`UEP_ADDR_W-1:0] next_addr(input logic [`UEP_ADDR_W-1:0] a);
    return (a == LAST_ADDR) ? '0 : a + 10'h001;
  endfunction

  uep_fifo #(
    .W     (DATA_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .ref_clk_in    (ref_clk_in),
    .sys_rst_in    (sys_rst_in),
    .in_valid_in   (wr_valid_in),
    .in_data_in    (wr_data_in),
    .in_ready_out  (wr_ready_out),
    .out_valid_out (fifo_valid),
    .out_data_out  (fifo_data),
    .out_ready_in  (q.st == uep_pkg::UEP_IDLE)
  );

  uep_tick #(
    .DIV (TICK_CYC)
  ) u_tick (
    .ref_clk_in (ref_clk_in),
    .sys_rst_in (sys_rst_in),
    .clr_in     (tick_clr),
    .tick_out   (tick)
  );

  // image only drains from the fifo while idle, so the fifo fills meanwhile
  assign fifo_take = fifo_valid && (q.st == uep_pkg::UEP_IDLE);
  assign nxt_addr  = next_addr(q.addr);

  always_comb begin
    d          = q;
    d.done     = 1'b0;
    d.err      = 1'b0;
    d.rd_valid = 1'b0;
    d.sync1    = data_lines_in;
    d.sync2    = q.sync1;
    tick_clr   = 1'b0;
    if (fifo_take) begin
      d.ld_ptr = next_addr(q.ld_ptr);
      if (q.ld_ptr == LAST_ADDR) begin
        d.loaded = 1'b1;
      end
    end
    case (q.st)
      uep_pkg::UEP_IDLE: begin
        if (start_in) begin
          if (start_ok(pulse_width_in, loop_count_in) && q.loaded) begin // R8
            d.st   = uep_pkg::UEP_ENTER;
            d.n    = loop_count_in;
            d.pw   = pulse_width_in;
            d.addr = '0;
            d.loop = '0;
            d.cnt  = '0;
            d.sel  = 1'b1; // R3
          end else begin
            d.err = 1'b1;
          end
        end else if (rd_req_in) begin
          d.st   = uep_pkg::UEP_READ;
          d.addr = `UEP_ADDR_W'(rd_addr_in); // R5
          d.cnt  = '0;
        end
      end
      uep_pkg::UEP_ENTER: begin
        // outputs float once select is high; only then drive the data pins
        d.cnt = q.cnt + 11'h001;
        if (hit(q.cnt, `UEP_SETUP_CYC)) begin
          d.st   = uep_pkg::UEP_SETUP;
          d.cnt  = '0;
          d.doe  = 1'b1; // R4
          d.data = img[q.addr[ADDR_W-1:0]]; // R14
        end
      end
      uep_pkg::UEP_SETUP: begin
        d.cnt = q.cnt + 11'h001;
        if (hit(q.cnt, `UEP_SETUP_CYC)) begin
          d.st     = uep_pkg::UEP_PULSE;
          d.cnt    = '0;
          d.pulse  = 1'b1; // R6
          tick_clr = 1'b1;
        end
      end
      uep_pkg::UEP_PULSE: begin
        if (tick) begin
          d.cnt = q.cnt + 11'h001;
          if (hit(q.cnt, {22'h0, q.pw})) begin
            d.st    = uep_pkg::UEP_HOLD;
            d.cnt   = '0;
            d.pulse = 1'b0; // R12
          end
        end
      end
      uep_pkg::UEP_HOLD: begin
        d.cnt = q.cnt + 11'h001;
        if (hit(q.cnt, `UEP_HOLD_CYC)) begin // R17
          d.cnt = '0;
          if ((q.addr == LAST_ADDR) && (q.loop == q.n - 10'h001)) begin
            d.st  = uep_pkg::UEP_EXIT; // R16
            d.doe = 1'b0;
          end else begin
            d.st   = uep_pkg::UEP_SETUP;
            d.addr = nxt_addr; // R10
            d.data = img[nxt_addr[ADDR_W-1:0]]; // R13
            if (q.addr == LAST_ADDR) begin
              d.loop = q.loop + 10'h001; // R7
            end
          end
        end
      end
      uep_pkg::UEP_EXIT: begin
        // release the pins, then drop select with the address untouched
        d.cnt = q.cnt + 11'h001;
        if (q.sel && hit(q.cnt, `UEP_HOLD_CYC)) begin
          d.sel = 1'b0; // R11
          d.cnt = '0;
        end else if (!q.sel && hit(q.cnt, `UEP_DPR_CYC)) begin
          d.st   = uep_pkg::UEP_IDLE;
          d.cnt  = '0;
          d.done = 1'b1;
        end
      end
      uep_pkg::UEP_READ: begin
        d.cnt = q.cnt + 11'h001;
        if (hit(q.cnt, `UEP_DPR_CYC)) begin
          d.st       = uep_pkg::UEP_IDLE;
          d.cnt      = '0;
          d.rd_data  = q.sync2; // R1
          d.rd_valid = 1'b1;
        end
      end
      default: begin
        d.st    = uep_pkg::UEP_IDLE;
        d.sel   = 1'b0;
        d.pulse = 1'b0;
        d.doe   = 1'b0;
      end
    endcase
  end

  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      q      <= '0;
      q.st   <= uep_pkg::UEP_IDLE;
      q.data <= `UEP_ERASED;
    end else begin
      q <= d;
    end
    if (fifo_take) begin
      img[q.ld_ptr[ADDR_W-1:0]] <= fifo_data; // R2
    end
  end

  assign loaded_out               = q.loaded;
  assign rd_data_out              = q.rd_data;
  assign rd_valid_out             = q.rd_valid;
  assign busy_out                 = q.st != uep_pkg::UEP_IDLE;
  assign done_out                 = q.done;
  assign err_out                  = q.err;
  assign loop_out                 = q.loop;
  assign addr_out                 = q.addr[ADDR_W-1:0];
  assign data_lines_out           = q.data;
  assign data_lines_oe_out        = q.doe;
  assign select_program_level_out = q.sel;
  assign prog_pulse_out           = q.pulse;

  // helper state read only by the checks below
  int unsigned       plen_q;
  int unsigned       stab_q;
  logic [ADDR_W-1:0] last_addr_q;
  logic              seen_q;

  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      plen_q      <= 0;
      stab_q      <= 0;
      last_addr_q <= '0;
      seen_q      <= 1'b0;
    end else begin
      plen_q <= d.pulse ? plen_q + 1 : 0;
      stab_q <= (d.addr != q.addr || d.data != q.data) ? 0 : stab_q + 1;
      if (d.pulse && !q.pulse) begin
        last_addr_q <= d.addr[ADDR_W-1:0];
        seen_q      <= 1'b1;
      end
      if (q.st == uep_pkg::UEP_IDLE) begin
        seen_q <= 1'b0;
      end
    end
  end

  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (sys_rst_in);

  pulse_needs_sel_a: // R3
    assert property (prog_pulse_out |-> select_program_level_out
                     && $past(select_program_level_out, 2))
    else $error("program pulse without program-level select");

  drive_in_prog_a: // R4
    assert property ($rose(prog_pulse_out) |-> data_lines_oe_out
                     ##1 data_lines_oe_out)
    else $error("data lines not driven around a pulse");

  pulse_width_a: // R9
    assert property ($fell(prog_pulse_out) |->
                     $past(plen_q) >= PW_MIN_CYC && $past(plen_q) <= PW_MAX_CYC)
    else $error("program pulse width out of range");

  steady_pulse_a: // R17
    assert property ((prog_pulse_out || $fell(prog_pulse_out)) |->
                     $stable(addr_out) && $stable(data_lines_out))
    else $error("address or data moved during a pulse");

  setup_time_a: // R17
    assert property ($rose(prog_pulse_out) |-> $past(stab_q) + 1 >= `UEP_SETUP_CYC)
    else $error("pulse raised before address and data setup");

  new_addr_a: // R10
    assert property ($rose(prog_pulse_out) && $past(seen_q) |->
                     addr_out != $past(last_addr_q))
    else $error("two pulses in succession on one address");

  addr_walk_a: // R16
    assert property (select_program_level_out && $past(select_program_level_out)
                     && $changed(addr_out) |->
                     addr_out == ADDR_W'($past(addr_out) + 1'b1))
    else $error("program address did not step by one with wrap");

  sel_exit_a: // R11
    assert property ($fell(select_program_level_out) |->
                     !prog_pulse_out && !data_lines_oe_out && $stable(addr_out)
                     ##1 $stable(addr_out))
    else $error("select fell out of order with pulse or address");

  start_gate_a: // R8
    assert property (q.st == uep_pkg::UEP_ENTER && $past(q.st) == uep_pkg::UEP_IDLE
                     |-> {22'h0, q.n} * {22'h0, q.pw} >= TOTAL_US)
    else $error("sequence started with too little total time");

  loop_end_a: // R7
    assert property ($rose(done_out) |-> loop_out == q.n - 10'h001 && &addr_out)
    else $error("sequence ended before n full passes");

endmodule // uep_ctrl

// File: design/uep_fifo.sv
// uep_fifo: small synchronous fifo with valid/ready on both sides
// assumes one clock; DEPTH is a power of two
`timescale 1ns/1ps

module uep_fifo #(
  parameter int unsigned W     = 8,
  parameter int unsigned DEPTH = 8
) (
  input  wire logic         ref_clk_in,
  input  wire logic         sys_rst_in,
  input  wire logic         in_valid_in,
  input  wire logic [W-1:0] in_data_in,
  output logic              in_ready_out,
  output logic              out_valid_out,
  output logic [W-1:0]      out_data_out,
  input  wire logic         out_ready_in
);

  localparam int unsigned AW = $clog2(DEPTH);

  typedef struct packed {
    logic [AW:0] wp;
    logic [AW:0] rp;
  } uep_fifo_st_t;

  uep_fifo_st_t q;
  uep_fifo_st_t d;
  logic [W-1:0] mem [DEPTH];
  logic         push;
  logic         pop;

  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_chk
    $error("uep_fifo: DEPTH must be a power of two, at least 2");
  end

  assign in_ready_out  = (q.wp ^ q.rp) != {1'b1, {AW{1'b0}}};
  assign out_valid_out = q.wp != q.rp;
  assign out_data_out  = mem[q.rp[AW-1:0]];
  assign push          = in_valid_in && in_ready_out;
  assign pop           = out_valid_out && out_ready_in;

  always_comb begin
    d = q;
    if (push) begin
      d.wp = q.wp + (AW + 1)'(1);
    end
    if (pop) begin
      d.rp = q.rp + (AW + 1)'(1);
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      q <= '0;
    end else begin
      q <= d;
    end
    if (push) begin
      mem[q.wp[AW-1:0]] <= in_data_in;
    end
  end

endmodule // uep_fifo

// File: design/uep_tick.sv
// uep_tick: one-cycle enable every DIV clocks, restartable
// assumes clr_in comes from logic on the same clock
`timescale 1ns/1ps

module uep_tick #(
  parameter int unsigned DIV = 125
) (
  input  wire logic ref_clk_in,
  input  wire logic sys_rst_in,
  input  wire logic clr_in,
  output logic      tick_out
);

  localparam int unsigned CW = $clog2(DIV);

  logic [CW-1:0] cnt_q;
  logic [CW-1:0] cnt_d;

  if (DIV < 2) begin : g_chk
    $error("uep_tick: DIV must be at least 2");
  end

  assign tick_out = (cnt_q == CW'(DIV - 1));

  always_comb begin
    cnt_d = cnt_q + CW'(1);
    if (clr_in || tick_out) begin
      cnt_d = '0;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

endmodule // uep_tick

// File: dv/uep_eprom_model.sv
// uep_eprom_model: behavioural 8-bit uv-erasable prom on the far side of the programmer
// assumes select high means program level and prog high means the program pulse
`timescale 1ns/1ps

module uep_eprom_model #(
  parameter int unsigned AW     = 10,
  parameter int unsigned ACC_NS = 50
) (
  input  wire logic [AW-1:0] addr_in,
  input  wire logic [7:0]    dq_in,
  input  wire logic          dq_oe_in,
  input  wire logic          sel_prog_in,
  input  wire logic          prog_in,
  output logic [7:0]         dq_out
);
  logic [7:0]  mem [2**AW];
  int unsigned pulses [2**AW];
  int unsigned viol;
  realtime     t_rise;
  realtime     width_ns;
  logic        pulsed_here;

  initial begin
    for (int i = 0; i < 2**AW; i++) begin
      mem[i] = 8'hFF;
      pulses[i] = 0;
    end
    viol = 0;
    pulsed_here = 1'b0;
    t_rise = 0;
    width_ns = 0;
  end

  // a pulse is only legal in program mode with the data pins driven
  always @(posedge prog_in) begin
    t_rise = $realtime;
    if (sel_prog_in !== 1'b1 || dq_oe_in !== 1'b1) viol++;
    if (pulsed_here) viol++;
    pulsed_here = 1'b1;
    pulses[addr_in]++;
  end

  // only zeros are written; a zero never goes back to one
  always @(negedge prog_in) begin
    width_ns = $realtime - t_rise;
    if (sel_prog_in === 1'b1) mem[addr_in] = mem[addr_in] & dq_in;
  end

  always @(addr_in) begin
    if (prog_in === 1'b1) viol++;
    pulsed_here = 1'b0;
  end

  always @(dq_in) begin
    if (prog_in === 1'b1 && dq_oe_in === 1'b1) viol++;
  end

  always @(negedge sel_prog_in) begin
    if (prog_in === 1'b1) viol++;
  end

  // outputs only in read mode; otherwise the pins show the complement of the stored word
  assign #(ACC_NS) dq_out = (sel_prog_in === 1'b0 && dq_oe_in !== 1'b1) ?
                            mem[addr_in] : ~mem[addr_in];
endmodule // uep_eprom_model

// File: dv/uv_eprom_loop_programmer_test.sv
// uv_eprom_loop_programmer_test: self-checking bench of uep_ctrl with an eprom model
// assumes shortened timing parameters; all counts derive from the locals below
`timescale 1ns/1ps

module uv_eprom_loop_programmer_test;
  localparam int unsigned AW = 4;
  localparam int unsigned NW = 1 << AW;
  localparam int unsigned TK = 4;

  typedef struct {logic [9:0] pw; logic [9:0] n; logic err;} uep_row_t;
  uep_row_t rows [4] = '{'{10'h000, 10'h00A, 1'b1}, '{10'h00B, 10'h001, 1'b1},
                         '{10'h005, 10'h000, 1'b1}, '{10'h003, 10'h003, 1'b1}};

  logic            ref_clk_in;
  logic            sys_rst_in;
  logic            wr_valid_in;
  logic [7:0]      wr_data_in;
  logic            wr_ready_out;
  logic            loaded_out;
  logic            start_in;
  logic [9:0]      pulse_width_in;
  logic [9:0]      loop_count_in;
  logic            rd_req_in;
  logic [AW-1:0]   rd_addr_in;
  logic [7:0]      rd_data_out;
  logic            rd_valid_out;
  logic            busy_out;
  logic            done_out;
  logic            err_out;
  logic [9:0]      loop_out;
  logic [AW-1:0]   addr_out;
  logic [7:0]      data_lines_out;
  logic            data_lines_oe_out;
  logic [7:0]      data_lines_in;
  logic            select_program_level_out;
  logic            prog_pulse_out;
  int              err_count;
  int              total_checks;
  logic [7:0]      q;
  logic            err_seen;

  uep_ctrl #(.ADDR_W(AW), .DATA_W(8), .TICK_CYC(TK), .PW_MIN_US(1),
             .PW_MAX_US(10), .TOTAL_US(10)) u_dut (
    .ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in), .wr_valid_in(wr_valid_in),
    .wr_data_in(wr_data_in), .wr_ready_out(wr_ready_out), .loaded_out(loaded_out),
    .start_in(start_in), .pulse_width_in(pulse_width_in), .loop_count_in(loop_count_in),
    .rd_req_in(rd_req_in), .rd_addr_in(rd_addr_in), .rd_data_out(rd_data_out),
    .rd_valid_out(rd_valid_out), .busy_out(busy_out), .done_out(done_out),
    .err_out(err_out), .loop_out(loop_out), .addr_out(addr_out),
    .data_lines_out(data_lines_out), .data_lines_oe_out(data_lines_oe_out),
    .data_lines_in(data_lines_in), .select_program_level_out(select_program_level_out),
    .prog_pulse_out(prog_pulse_out));

  uep_eprom_model #(.AW(AW)) u_eprom (
    .addr_in(addr_out), .dq_in(data_lines_out), .dq_oe_in(data_lines_oe_out),
    .sel_prog_in(select_program_level_out), .prog_in(prog_pulse_out),
    .dq_out(data_lines_in));

  initial begin
    ref_clk_in = 1'b0;
    forever #4 ref_clk_in = ~ref_clk_in;
  end

  function automatic logic [7:0] img1(input int i);
    return (i % 4 == 3) ? 8'hFF : 8'hA5 ^ 8'(i * 19);
  endfunction

  function automatic logic [7:0] img2(input int i);
    return 8'h3C ^ 8'(i);
  endfunction

  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic chk_int(input string name, input longint exp, input longint got);
    total_checks++;
    if (got != exp) begin
      err_count++;
      $display("Error %s expected %0d seen %0d", name, exp, got);
    end
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // leaves valid high so back-to-back bytes need no second assignment
  task automatic push(input logic [7:0] b);
    int n;
    n = 0;
    wr_valid_in = 1'b1;
    wr_data_in = b;
    while (wr_ready_out !== 1'b1 && n < 5000) begin
      @(negedge ref_clk_in);
      n++;
    end
    @(negedge ref_clk_in);
  endtask

  // err_out stands one cycle only, so it is taken in the cycle after the start edge
  task automatic start_run(input logic [9:0] pw, input logic [9:0] n, output logic e);
    pulse_width_in = pw;
    loop_count_in = n;
    start_in = 1'b1;
    @(negedge ref_clk_in);
    e = err_out;
    start_in = 1'b0;
    @(negedge ref_clk_in);
  endtask

  task automatic wait_done();
    int n;
    n = 0;
    while (done_out !== 1'b1 && n < 200000) begin
      @(negedge ref_clk_in);
      n++;
    end
    chk("done", 16'h0001, {15'h0000, done_out});
  endtask

  task automatic rd(input int a, output logic [7:0] d);
    int n;
    n = 0;
    rd_req_in = 1'b1;
    rd_addr_in = AW'(a);
    @(negedge ref_clk_in);
    rd_req_in = 1'b0;
    while (rd_valid_out !== 1'b1 && n < 3000) begin
      @(negedge ref_clk_in);
      n++;
    end
    chk("rd_valid", 16'h0001, {15'h0000, rd_valid_out});
    d = rd_data_out;
    @(negedge ref_clk_in);
  endtask

  // end of a run: select down, pins released, address parked on the last word
  task automatic chk_end(input int runs, input int pw);
    chk("busy", 16'h0000, {15'h0000, busy_out});
    chk("select", 16'h0000, {15'h0000, select_program_level_out});
    chk("addr_end", 16'(NW - 1), 16'(addr_out));
    chk("oe", 16'h0000, {15'h0000, data_lines_oe_out});
    chk_int("width_ns", pw * TK * 8, longint'(u_eprom.width_ns));
    chk_int("viol", 0, u_eprom.viol);
    for (int i = 0; i < NW; i++) chk_int("pulses", runs, u_eprom.pulses[i]);
  endtask

  initial begin
    #(120000 * 8);
    err_count++;
    $display("Error watchdog expected done seen hang");
    test_done();
  end

  initial begin
    err_count = 0;
    total_checks = 0;
    sys_rst_in = 1'b1;
    wr_valid_in = 1'b0;
    wr_data_in = 8'h00;
    start_in = 1'b0;
    pulse_width_in = 10'h000;
    loop_count_in = 10'h000;
    rd_req_in = 1'b0;
    rd_addr_in = '0;
    repeat (10) @(negedge ref_clk_in);
    sys_rst_in = 1'b0;
    chk("prog_low", 16'h0000, {15'h0000, prog_pulse_out});
    chk("sel_rst", 16'h0000, {15'h0000, select_program_level_out});
    chk("ready_rst", 16'h0001, {15'h0000, wr_ready_out});
    start_run(10'h005, 10'h002, err_seen);
    chk("err_unloaded", 16'h0001, {15'h0000, err_seen});
    $display("test reset done");

    for (int i = 0; i < NW; i++) push(img1(i));
    wr_valid_in = 1'b0;
    repeat (20) @(negedge ref_clk_in);
    chk("loaded", 16'h0001, {15'h0000, loaded_out});
    foreach (rows[k]) begin
      start_run(rows[k].pw, rows[k].n, err_seen);
      chk("err_row", {15'h0000, rows[k].err}, {15'h0000, err_seen});
      chk("busy_row", 16'h0000, {15'h0000, busy_out});
    end
    $display("test refusals done");

    start_run(10'h005, 10'h002, err_seen);
    chk("err_ok", 16'h0000, {15'h0000, err_seen});
    chk("sel_up", 16'h0001, {15'h0000, select_program_level_out});
    chk("prog_wait", 16'h0000, {15'h0000, prog_pulse_out});
    for (int i = 0; i < 8; i++) push(img2(i));
    wr_valid_in = 1'b0;
    repeat (3) @(negedge ref_clk_in);
    chk("fifo_full", 16'h0000, {15'h0000, wr_ready_out});
    wait_done();
    @(negedge ref_clk_in);
    chk_end(2, 5);
    for (int i = 0; i < NW; i++) chk("mem1", 16'(img1(i)), 16'(u_eprom.mem[i]));
    $display("test first run done");

    repeat (20) @(negedge ref_clk_in);
    start_run(10'h00A, 10'h001, err_seen);
    chk("err_max", 16'h0000, {15'h0000, err_seen});
    wait_done();
    @(negedge ref_clk_in);
    chk_end(3, 10);
    for (int i = 0; i < NW; i++) begin
      rd(i, q);
      chk("rd_data", 16'(img1(i) & ((i < 8) ? img2(i) : img1(i))), 16'(q));
    end
    $display("test update and read done");
    test_done();
  end
endmodule // uv_eprom_loop_programmer_test

// File: inc/uep_map.svh
// uep_map.svh: sizes, limits and timing counts of the eprom programmer
// assumes a 125 MHz controller clock; times are in ns or us as named
`ifndef UEP_MAP_SVH
`define UEP_MAP_SVH

`define UEP_CLK_NS      8
`define UEP_ADDR_W      10
`define UEP_DATA_W      8
`define UEP_LOOP_W      10
`define UEP_CNT_W       11
`define UEP_FIFO_DEPTH  8
`define UEP_ERASED      8'hFF

`define UEP_US_NS       1000
`define UEP_TICK_CYC    (`UEP_US_NS / `UEP_CLK_NS)
`define UEP_T_SETUP_NS  10000
`define UEP_SETUP_CYC   ((`UEP_T_SETUP_NS + `UEP_CLK_NS - 1) / `UEP_CLK_NS)
`define UEP_T_HOLD_NS   1000
`define UEP_HOLD_CYC    ((`UEP_T_HOLD_NS + `UEP_CLK_NS - 1) / `UEP_CLK_NS)
`define UEP_T_DPR_NS    10000
`define UEP_DPR_CYC     ((`UEP_T_DPR_NS + `UEP_CLK_NS - 1) / `UEP_CLK_NS)

`define UEP_PW_MIN_US   100
`define UEP_PW_MAX_US   1000
`define UEP_TOTAL_US    100000

`endif

// File: inc/uep_pkg.sv
// uep_pkg: state and register types of the eprom programmer
// assumes uep_map.svh is on the include path
`include "uep_map.svh"

package uep_pkg;

  typedef enum logic [2:0] {
    UEP_IDLE  = 3'h0,
    UEP_ENTER = 3'h1,
    UEP_SETUP = 3'h2,
    UEP_PULSE = 3'h3,
    UEP_HOLD  = 3'h4,
    UEP_EXIT  = 3'h5,
    UEP_READ  = 3'h6
  } uep_state_t;

  typedef struct packed {
    uep_state_t                 st;
    logic [`UEP_ADDR_W-1:0]     addr;
    logic [`UEP_DATA_W-1:0]     data;
    logic [`UEP_LOOP_W-1:0]     loop;
    logic [`UEP_LOOP_W-1:0]     n;
    logic [`UEP_LOOP_W-1:0]     pw;
    logic [`UEP_CNT_W-1:0]      cnt;
    logic [`UEP_ADDR_W-1:0]     ld_ptr;
    logic                       loaded;
    logic                       sel;
    logic                       pulse;
    logic                       doe;
    logic                       done;
    logic                       err;
    logic [`UEP_DATA_W-1:0]     rd_data;
    logic                       rd_valid;
    logic [`UEP_DATA_W-1:0]     sync1;
    logic [`UEP_DATA_W-1:0]     sync2;
  } uep_regs_t;

endpackage
